// file: cfgws_consts.svh
// Purpose: Constants for the configuration word store
// Assumes: Included by the package and the design modules
// Notes: Offsets are program memory word addresses
`ifndef CFGWS_CONSTS_SVH
`define CFGWS_CONSTS_SVH
`define CFGWS_ADDR_W 14
`define CFGWS_WORD_W 14
`define CFGWS_CFG_ADDR 14'h2007
`define CFGWS_CFG_LO 14'h2000
`define CFGWS_CFG_HI 14'h3FFF
`define CFGWS_ERASED 14'h3FFF
`define CFGWS_IMPL_MASK 14'h31FF
`define CFGWS_CELL_ERASED 1'b1
`define CFGWS_CELL_PROG 1'b0
`define CFGWS_BG_HI 13
`define CFGWS_BG_LO 12
`define CFGWS_DPROT 8
`define CFGWS_CPROT 7
`define CFGWS_BOD 6
`define CFGWS_XRST 5
`define CFGWS_PWRUP 4
`define CFGWS_WDOG 3
`define CFGWS_OSC_HI 2
`define CFGWS_OSC_LO 0
`endif

// file: cfgws_pkg.sv
// Purpose: Types for the configuration word store
// Assumes: cfgws_consts.svh holds the numbers
// Notes: Types only
`include "cfgws_consts.svh"
package cfgws_pkg;
  typedef logic [`CFGWS_WORD_W-1:0] cfgws_word_t;
  typedef logic [`CFGWS_ADDR_W-1:0] cfgws_addr_t;
  typedef enum logic [2:0] {
    CFGWS_RESET = 3'b001,
    CFGWS_LOAD = 3'b010,
    CFGWS_RUN = 3'b100
  } cfgws_state_t;
endpackage

// file: cfgws_cell.sv
// Purpose: Nonvolatile-style storage of the configuration cells
// Assumes: Programming only clears cells; erase sets them all
// Notes: Read data come out of a register
`timescale 1ns/1ps
`include "cfgws_consts.svh"
module cfgws_cell (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Write side
  input wire logic i_prog,
  input wire logic i_erase,
  input wire cfgws_pkg::cfgws_word_t i_wdata,
  // Read side
  output cfgws_pkg::cfgws_word_t o_rdata
);
  import cfgws_pkg::*;

  // Power-up state of an unwritten array; reset leaves it alone
  cfgws_word_t cell_q = `CFGWS_ERASED;
  cfgws_word_t cell_d, rd_q, rd_d;

  // =====================================================
  // Cell array
  always_comb begin
    cell_d = cell_q;
    if (i_erase) begin
      cell_d = `CFGWS_ERASED; // see R01
    end else if (i_prog) begin
      cell_d = cell_q & i_wdata; // see R02
    end
    rd_d = cell_d & `CFGWS_IMPL_MASK;
  end

  // Cells model flash: reset does not erase them, only the output register
  always_ff @(posedge i_clk) begin
    cell_q <= cell_d;
    if (!i_rst_n) begin
      rd_q <= `CFGWS_ERASED & `CFGWS_IMPL_MASK;
    end else begin
      rd_q <= rd_d;
    end
  end

  assign o_rdata = rd_q;
endmodule

// file: cfgws_top.sv
// Purpose: Configuration word store with programming-mode access
// Assumes: Inputs synchronous to I_CORE_CLK; programmer drives address and strobes
// Notes: Latched word and fields change only across a reset
// Operation
// R01: A never-programmed cell reads back as one.
// R02: A programmed cell reads back as zero.
// R03: The word lives at 2007h and is returned there in programming mode.
// R04: The word lies outside user program memory; fetches never reach it.
// R05: 2000h to 3FFFh is reachable only in programming mode.
// R06: The word is latched during reset and held as static control outputs; the code latches it on the second rising edge after reset release.
`timescale 1ns/1ps
`include "cfgws_consts.svh"
module cfgws_top (
  // Clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RST_N,
  // Programmer port
  input wire logic I_PROG_MODE,
  input wire cfgws_pkg::cfgws_addr_t I_PROG_ADDR,
  input wire logic I_PROG_WR,
  input wire logic I_PROG_ERASE,
  input wire logic I_PROG_RD,
  input wire cfgws_pkg::cfgws_word_t I_PROG_WDATA,
  output cfgws_pkg::cfgws_word_t O_PROG_RDATA,
  output logic O_PROG_RVALID,
  // Core fetch check
  input wire cfgws_pkg::cfgws_addr_t I_FETCH_ADDR,
  output logic O_FETCH_CFG_HIT,
  // Static configuration outputs
  output cfgws_pkg::cfgws_word_t O_CONFIG_WORD,
  output logic [1:0] O_BANDGAP_TRIM,
  output logic O_DATA_EEPROM_PROTECT,
  output logic O_PROGRAM_CODE_PROTECT,
  output logic O_BROWNOUT_DETECT_ENABLE,
  output logic O_EXTERNAL_RESET_PIN_ENABLE,
  output logic O_POWERUP_DELAY_ENABLE,
  output logic O_WATCHDOG_ENABLE_BIT,
  output logic [2:0] O_OSCILLATOR_SELECT_FIELD
);
  import cfgws_pkg::*;

  // =====================================================
  // Internal signals
  // Word seen on the config word and field outputs while reset holds: erased, unused bits clear
  localparam cfgws_word_t RST_WORD = `CFGWS_ERASED & `CFGWS_IMPL_MASK;

  cfgws_word_t cell_rdata;
  cfgws_state_t st_q;
  cfgws_state_t st_d;
  logic load_now;
  cfgws_word_t cfg_q;
  cfgws_word_t cfg_d;
  logic [1:0] bg_q;
  logic [1:0] bg_d;
  logic dprot_q;
  logic dprot_d;
  logic cprot_q;
  logic cprot_d;
  logic bod_q;
  logic bod_d;
  logic xrst_q;
  logic xrst_d;
  logic pwrup_q;
  logic pwrup_d;
  logic wdog_q;
  logic wdog_d;
  logic [2:0] osc_q;
  logic [2:0] osc_d;
  cfgws_word_t rdata_q;
  cfgws_word_t rdata_d;
  logic rvalid_q;
  logic rvalid_d;
  logic hit_q;
  logic hit_d;
  logic addr_above_lo;
  logic addr_below_hi;
  logic in_cfg_space;
  logic at_cfg_word;
  logic wr_ok;
  logic er_ok;
  logic rd_ok;

  // =====================================================
  // Address decode
  assign addr_above_lo = (I_PROG_ADDR >= `CFGWS_CFG_LO);
  assign addr_below_hi = (I_PROG_ADDR <= `CFGWS_CFG_HI);
  // Whole window gated by mode, so a running core never reaches it
  assign in_cfg_space = I_PROG_MODE && addr_above_lo && addr_below_hi; // see R05
  assign at_cfg_word = in_cfg_space && (I_PROG_ADDR == `CFGWS_CFG_ADDR); // see R03
  assign wr_ok = at_cfg_word && I_PROG_WR;
  // Bulk erase also needs programming mode
  assign er_ok = I_PROG_MODE && I_PROG_ERASE; // see R05
  assign rd_ok = in_cfg_space && I_PROG_RD; // see R05

  // =====================================================
  // Cell array
  cfgws_cell u_cell (
    .i_clk(I_CORE_CLK),
    .i_rst_n(I_RST_N),
    .i_prog(wr_ok),
    .i_erase(er_ok),
    .i_wdata(I_PROG_WDATA),
    .o_rdata(cell_rdata)
  );

  // =====================================================
  // Load sequencer
  always_comb begin
    st_d = st_q;
    load_now = 1'b0;
    case (st_q)
      CFGWS_RESET: begin
        st_d = CFGWS_LOAD;
      end
      CFGWS_LOAD: begin
        // Cell register has settled one cycle after reset release
        load_now = 1'b1;
        st_d = CFGWS_RUN;
      end
      CFGWS_RUN: begin
        st_d = CFGWS_RUN;
      end
      default: begin
        st_d = CFGWS_RESET;
      end
    endcase
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      st_q <= CFGWS_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // =====================================================
  // Configuration word latch
  always_comb begin
    cfg_d = cfg_q;
    if (load_now) begin
      cfg_d = cell_rdata; // see R06
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      cfg_q <= RST_WORD;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // =====================================================
  // Field registers
  // Own flops per field keep every output a flop, not a slice of logic
  always_comb begin
    bg_d = bg_q;
    dprot_d = dprot_q;
    cprot_d = cprot_q;
    bod_d = bod_q;
    xrst_d = xrst_q;
    pwrup_d = pwrup_q;
    wdog_d = wdog_q;
    osc_d = osc_q;
    if (load_now) begin
      bg_d = cell_rdata[`CFGWS_BG_HI:`CFGWS_BG_LO]; // see R06
      dprot_d = cell_rdata[`CFGWS_DPROT];
      cprot_d = cell_rdata[`CFGWS_CPROT];
      bod_d = cell_rdata[`CFGWS_BOD];
      xrst_d = cell_rdata[`CFGWS_XRST];
      pwrup_d = cell_rdata[`CFGWS_PWRUP];
      wdog_d = cell_rdata[`CFGWS_WDOG];
      osc_d = cell_rdata[`CFGWS_OSC_HI:`CFGWS_OSC_LO];
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      bg_q <= RST_WORD[`CFGWS_BG_HI:`CFGWS_BG_LO];
      dprot_q <= RST_WORD[`CFGWS_DPROT];
      cprot_q <= RST_WORD[`CFGWS_CPROT];
      bod_q <= RST_WORD[`CFGWS_BOD];
      xrst_q <= RST_WORD[`CFGWS_XRST];
      pwrup_q <= RST_WORD[`CFGWS_PWRUP];
      wdog_q <= RST_WORD[`CFGWS_WDOG];
      osc_q <= RST_WORD[`CFGWS_OSC_HI:`CFGWS_OSC_LO];
    end else begin
      bg_q <= bg_d;
      dprot_q <= dprot_d;
      cprot_q <= cprot_d;
      bod_q <= bod_d;
      xrst_q <= xrst_d;
      pwrup_q <= pwrup_d;
      wdog_q <= wdog_d;
      osc_q <= osc_d;
    end
  end

  // =====================================================
  // Programmer read path
  always_comb begin
    rdata_d = rdata_q;
    rvalid_d = 1'b0;
    if (rd_ok) begin
      rvalid_d = 1'b1;
      if (at_cfg_word) begin
        rdata_d = cell_rdata; // see R01 R02 R03
      end else begin
        // Other config locations are not modelled; they read as erased
        rdata_d = `CFGWS_ERASED; // see R01
      end
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      rdata_q <= `CFGWS_ERASED;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // =====================================================
  // Core fetch check
  always_comb begin
    // Config space sits above user memory, so a fetch there is flagged
    hit_d = (I_FETCH_ADDR >= `CFGWS_CFG_LO); // see R04
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      hit_q <= 1'b0;
    end else begin
      hit_q <= hit_d;
    end
  end

  // =====================================================
  // Outputs, all straight from flip-flops
  // Programming later does not change the config word and fields until the next reset
  assign O_CONFIG_WORD = cfg_q; // see R06
  assign O_BANDGAP_TRIM = bg_q;
  assign O_DATA_EEPROM_PROTECT = dprot_q;
  assign O_PROGRAM_CODE_PROTECT = cprot_q;
  assign O_BROWNOUT_DETECT_ENABLE = bod_q;
  assign O_EXTERNAL_RESET_PIN_ENABLE = xrst_q;
  assign O_POWERUP_DELAY_ENABLE = pwrup_q;
  assign O_WATCHDOG_ENABLE_BIT = wdog_q;
  assign O_OSCILLATOR_SELECT_FIELD = osc_q;
  assign O_PROG_RDATA = rdata_q;
  assign O_PROG_RVALID = rvalid_q;
  assign O_FETCH_CFG_HIT = hit_q;
endmodule

// file: cfgws_asserts.sv
// Purpose: Port checks for the store
// Assumes: Bound to cfgws_top
// Notes: Read data judged a cycle on
`timescale 1ns/1ps
module cfgws_chk (
  // Watched ports
  input wire logic I_CORE_CLK,
  input wire logic I_RST_N,
  input wire logic I_PROG_MODE,
  input wire logic [13:0] I_PROG_ADDR,
  input wire logic I_PROG_RD,
  input wire logic [13:0] O_PROG_RDATA,
  input wire logic O_PROG_RVALID,
  input wire logic [13:0] I_FETCH_ADDR,
  input wire logic O_FETCH_CFG_HIT,
  input wire logic [13:0] O_CONFIG_WORD
);
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_N);
  wire rq = I_PROG_MODE && I_PROG_RD && I_PROG_ADDR[13];
  wire cf = I_PROG_ADDR == 14'h2007;
  chk_rd_answer: assert property (rq |=> O_PROG_RVALID) else $error("no valid");
  chk_rd_refused: assert property (!rq |=> !O_PROG_RVALID) else $error("stray");
  chk_erased_read: assert property (rq && !cf |=> O_PROG_RDATA == 14'h3FFF)
    else $error("not erased");
  chk_unused_zero: assert property (rq && cf |=> O_PROG_RDATA[11:9] == 3'h0)
    else $error("unused set");
  chk_fetch_hit: assert property (I_FETCH_ADDR[13] |=> O_FETCH_CFG_HIT)
    else $error("no hit");
  chk_fetch_miss: assert property (!I_FETCH_ADDR[13] |=> !O_FETCH_CFG_HIT)
    else $error("false hit");
  // Three quiet edges cover load and latch
  chk_word_static: assert property ($past(I_RST_N) && $past(I_RST_N, 2)
    && $past(I_RST_N, 3) |-> $stable(O_CONFIG_WORD)) else $error("word moved");
endmodule

// file: cfgws_pgm.sv
// Purpose: Programmer model
// Assumes: Drives on falling edges
// Notes: Released lines show inverse
`timescale 1ns/1ps
module cfgws_pgm (
  // Clock
  input wire logic i_clk,
  // Strobes and data
  output logic o_mode,
  output logic o_wr,
  output logic o_erase,
  output logic o_rd,
  output logic [13:0] o_addr,
  output logic [13:0] o_wdata,
  // Answer
  input wire logic [13:0] i_rdata,
  input wire logic i_rvalid
);
  initial {o_mode, o_wr, o_erase, o_rd, o_addr, o_wdata} = '0;
  task automatic acc(input logic [3:0] c, input logic [13:0] a, d,
      output logic [13:0] q, output logic v);
    v = 1'b0;
    q = ~a;
    @(negedge i_clk);
    o_mode = c[3];
    @(negedge i_clk);
    {o_wr, o_erase, o_rd, o_addr, o_wdata} = {c[2:0], a, d};
    @(negedge i_clk);
    {o_wr, o_erase, o_rd, o_addr, o_wdata} = {3'h0, ~a, ~d};
    for (int i = 0; i < 3 && !v; i++) begin
      if (i_rvalid === 1'b1) begin
        v = 1'b1;
        q = i_rdata;
      end else begin
        @(negedge i_clk);
      end
    end
  endtask
endmodule

// file: tb.sv
// Purpose: Bench for the store
// Assumes: Inputs move on falling edges
// Notes: Cells survive the second reset
`timescale 1ns/1ps
module tb;
  import cfgws_pkg::*;
  logic clk, rst_n, md, wr, er, rd, rv, hit, v;
  cfgws_addr_t ad, fa;
  cfgws_word_t wd, rdat, cw, q;
  wire [10:0] f;
  int err_count = 0;
  int n_checks = 0;
  cfgws_top i_cfgws_top (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_PROG_MODE(md),
    .I_PROG_ADDR(ad), .I_PROG_WR(wr), .I_PROG_ERASE(er), .I_PROG_RD(rd),
    .I_PROG_WDATA(wd), .O_PROG_RDATA(rdat), .O_PROG_RVALID(rv), .I_FETCH_ADDR(fa),
    .O_FETCH_CFG_HIT(hit), .O_CONFIG_WORD(cw), .O_BANDGAP_TRIM(f[10:9]),
    .O_DATA_EEPROM_PROTECT(f[8]), .O_PROGRAM_CODE_PROTECT(f[7]),
    .O_BROWNOUT_DETECT_ENABLE(f[6]), .O_EXTERNAL_RESET_PIN_ENABLE(f[5]),
    .O_POWERUP_DELAY_ENABLE(f[4]), .O_WATCHDOG_ENABLE_BIT(f[3]),
    .O_OSCILLATOR_SELECT_FIELD(f[2:0]));
  cfgws_pgm i_cfgws_pgm (.i_clk(clk), .o_mode(md), .o_wr(wr), .o_erase(er), .o_rd(rd),
    .o_addr(ad), .o_wdata(wd), .i_rdata(rdat), .i_rvalid(rv));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic cmp(input string n, input cfgws_word_t e, s);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic results;
    if (err_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic rst;
    rst_n = 1'b0;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
  endtask
  task automatic pa(input logic [3:0] c, input cfgws_addr_t a, input cfgws_word_t d);
    i_cfgws_pgm.acc(c, a, d, q, v);
  endtask
  // Missing answer ends the run
  task automatic rdc(input cfgws_addr_t a, input cfgws_word_t e);
    pa(4'h9, a, 14'h0000);
    if (v !== 1'b1) begin
      err_count++;
      results;
    end else begin
      cmp("rd", e, q);
    end
  endtask
  initial begin
    fa = 14'h1FFF;
    rst;
    cmp("cw", 14'h31FF, cw);
    cmp("hit", 14'h0000, {13'h0, hit});
    pa(4'hC, 14'h2006, 14'h0000);
    pa(4'h4, 14'h2007, 14'h0000);
    rdc(14'h2006, 14'h3FFF);
    pa(4'hC, 14'h2007, 14'h2A5A);
    rdc(14'h2007, 14'h205A);
    cmp("cw", 14'h31FF, cw);
    fa = 14'h2007;
    rst;
    cmp("cw", 14'h205A, cw);
    cmp("f", 14'h045A, {3'h0, f});
    cmp("hit", 14'h0001, {13'h0, hit});
    pa(4'h1, 14'h2007, 14'h0000);
    cmp("v", 14'h0000, {13'h0, v});
    pa(4'hD, 14'h2007, 14'h0000);
    cmp("rdwr", 14'h205A, q);
    rdc(14'h2007, 14'h0000);
    pa(4'h2, 14'h2007, 14'h0000);
    rdc(14'h2007, 14'h0000);
    pa(4'hE, 14'h2007, 14'h0000);
    rdc(14'h2007, 14'h31FF);
    rst;
    cmp("cw", 14'h31FF, cw);
    cmp("f", 14'h07FF, {3'h0, f});
    results;
  end
endmodule
bind cfgws_top cfgws_chk i_cfgws_chk (.I_CORE_CLK, .I_RST_N, .I_PROG_MODE, .I_PROG_ADDR,
  .I_PROG_RD, .O_PROG_RDATA, .O_PROG_RVALID, .I_FETCH_ADDR, .O_FETCH_CFG_HIT,
  .O_CONFIG_WORD);
